// ===== hw/timer_defines.svh
// Register indices, field positions, reset values and timing counts
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH
// Register indices; the byte address is four times the index
`define RUNCTL_IDX   8'h88
`define MODESEL_IDX  8'h89
`define T0LO_IDX     8'h8a
`define T1LO_IDX     8'h8b
`define T0HI_IDX     8'h8c
`define T1HI_IDX     8'h8d
`define CLKDIV_IDX   8'h8e
// Run and external interrupt control fields
`define B_T1OVF      7
`define B_T1RUN      6
`define B_T0OVF      5
`define B_T0RUN      4
`define B_X1REQ      3
`define B_X1TYPE     2
`define B_X0REQ      1
`define B_X0TYPE     0
// Mode select fields
`define B_GATE1      7
`define B_CT1        6
`define B_GATE0      3
`define B_CT0        2
// Clock divide select fields
`define B_T1DIV      4
`define B_T0DIV      3
// Reset values and timing
`define RESET_BYTE   8'h00
`define PRESCALE_DEF 12
`define RESP_OKAY    2'b00
`define RESP_SLVERR  2'b10
`endif

// ===== hw/timer_pkg.sv
// Types shared by the timer and external interrupt control block
package timer_pkg;
  typedef enum logic [1:0] {
    MODE_13BIT  = 2'b00,
    MODE_16BIT  = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT  = 2'b11
  } mode_t;
  typedef enum logic [1:0] {
    WR_COLLECT = 2'b01,
    WR_RESP    = 2'b10
  } wr_state_t;
  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_DATA = 2'b10
  } rd_state_t;
  typedef struct packed {
    logic ovf;
    logic [7:0] hi;
    logic [7:0] lo;
  } count_t;
  typedef struct packed {
    logic extirq1_pin;
    logic extirq0_pin;
    logic count_input_pin_one;
    logic count_input_pin_zero;
  } pins_t;
  typedef struct packed {
    logic t1_ovf;
    logic t0_ovf;
    logic extirq1;
    logic extirq0;
  } ack_t;
  typedef struct packed {
    logic t1_overflow_flag;
    logic t0_overflow_flag;
    logic extirq1_request_flag;
    logic extirq0_request_flag;
  } flags_t;
endpackage

// ===== hw/dual_timer_extint_control.sv
// Two timer/counters and two external interrupt flags behind AXI4-Lite
//
// Overview of operation
// RULE1: Timer 1 overflow sets its flag; software can also set or clear it.
// RULE2: Entering the timer 1 service routine clears its overflow flag.
// RULE3: Timer 1 run bit low freezes both count bytes; high enables it.
// RULE4: Timer 0 overflow sets its flag; service entry or software clear it.
// RULE5: Timer 0 run bit low freezes both count bytes; high enables it. In mode 11 the high byte follows timer 1's run bit instead.
// RULE6: Edge mode: falling edge sets request 1 until software or service.
// RULE7: Level mode: request 1 mirrors inverted pin; software writes ignored.
// RULE8: Edge mode: falling edge sets request 0 until software or service.
// RULE9: Level mode: request 0 mirrors inverted pin; software cannot change.
// RULE10: Trigger type bits 2 and 0: zero low level, one falling edge.
// RULE11: Gating bit set means counting also needs its gate pin high.
// RULE12: Timer 1 source bit: internal clock or falling edges of count pin.
// RULE13: Timer 0 source bit: internal clock or falling edges of count pin.
// RULE14: Timer 1 modes: 13-bit, 16-bit, 8-bit auto-reload, halted.
// RULE15: Timer 0 modes 00, 01, 10: 13-bit, 16-bit, 8-bit auto-reload.
// RULE16: Timer 0 mode 11 splits into low counter and high timer.
// RULE17: Run and interrupt control register at 88H, resets to zero.
// RULE18: Mode register at 89H, zero reset, upper nibble timer 1.
// RULE19: Internal clock is system clock over twelve or undivided, per timer.
// RULE20: Each timer count lives in readable, writable low and high bytes.
// RULE21: Wrap to zero raises overflow that cycle; reload copies high byte.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`include "timer_defines.svh"
module dual_timer_extint_control #(
  parameter int ADDR_W   = 12,
  parameter int PRESCALE = `PRESCALE_DEF
) (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire timer_pkg::pins_t      pins,
  input  wire timer_pkg::ack_t       isr_ack,
  output timer_pkg::flags_t          flags
);
  localparam int DIV_W = $clog2(PRESCALE);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(PRESCALE - 1);

  if (PRESCALE < 2) begin : g_bad_prescale
    $error("PRESCALE must be at least 2");
  end
  if (ADDR_W < 10) begin : g_bad_addr
    $error("ADDR_W must be at least 10");
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [8:0] word_index(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] upper;
    upper = a >> 10;
    word_index = {(upper == '0), a[9:2]};
  endfunction

  function automatic timer_pkg::count_t step(input timer_pkg::mode_t m,
                                             input logic [7:0] lo,
                                             input logic [7:0] hi);
    timer_pkg::count_t r;
    logic              carry;
    r.lo  = lo + 8'h01;
    r.hi  = hi;
    r.ovf = 1'b0;
    carry = 1'b0;
    case (m)
      timer_pkg::MODE_13BIT: begin
        carry = (lo[4:0] == 5'h1f);
        r.lo  = {lo[7:5], lo[4:0] + 5'h01};
        r.hi  = carry ? hi + 8'h01 : hi;
        r.ovf = carry && (hi == 8'hff);
      end
      timer_pkg::MODE_16BIT: begin
        carry = (lo == 8'hff);
        r.hi  = carry ? hi + 8'h01 : hi;
        r.ovf = carry && (hi == 8'hff);
      end
      timer_pkg::MODE_RELOAD: begin
        r.ovf = (lo == 8'hff);
        r.lo  = r.ovf ? hi : lo + 8'h01;
      end
      default: begin
        r.ovf = (lo == 8'hff);
      end
    endcase
    step = r;
  endfunction

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic                 t1_ovf_q;
  logic                 t1_run_q;
  logic                 t0_ovf_q;
  logic                 t0_run_q;
  logic                 x1_req_q;
  logic                 x1_type_q;
  logic                 x0_req_q;
  logic                 x0_type_q;
  logic [7:0]           mode_q;
  logic [1:0]           clkdiv_q;
  logic [7:0]           t0_lo_q;
  logic [7:0]           t0_hi_q;
  logic [7:0]           t1_lo_q;
  logic [7:0]           t1_hi_q;
  logic [DIV_W-1:0]     div_q;
  timer_pkg::pins_t     pins_prev_q;

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  timer_pkg::wr_state_t wr_state_q;
  timer_pkg::rd_state_t rd_state_q;
  logic                 aw_have_q;
  logic                 w_have_q;
  logic [ADDR_W-1:0]    awaddr_q;
  logic [7:0]           wbyte_q;
  logic                 wstrb0_q;
  logic [1:0]           bresp_q;
  logic [31:0]          rdata_q;
  logic [1:0]           rresp_q;
  logic                 wr_do;
  logic                 wr_en;
  logic [8:0]           wr_dec;
  logic [8:0]           rd_dec;
  logic [7:0]           rd_byte;

  assign s_axi_awready = (wr_state_q == timer_pkg::WR_COLLECT) && !aw_have_q;
  assign s_axi_wready  = (wr_state_q == timer_pkg::WR_COLLECT) && !w_have_q;
  assign s_axi_bvalid  = (wr_state_q == timer_pkg::WR_RESP);
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = (rd_state_q == timer_pkg::RD_IDLE);
  assign s_axi_rvalid  = (rd_state_q == timer_pkg::RD_DATA);
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  assign wr_do  = (wr_state_q == timer_pkg::WR_COLLECT) && aw_have_q &&
                  w_have_q;
  assign wr_dec = word_index(awaddr_q);
  assign rd_dec = word_index(s_axi_araddr);

  // Only the lowest byte lane carries register data
  always_comb begin
    wr_en = 1'b0;
    if (wr_do && wstrb0_q && wr_dec[8]) begin
      case (wr_dec[7:0])
        `RUNCTL_IDX, `MODESEL_IDX, `T0LO_IDX, `T1LO_IDX,
        `T0HI_IDX, `T1HI_IDX, `CLKDIV_IDX: wr_en = 1'b1;
        default: wr_en = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_state_q <= timer_pkg::WR_COLLECT;
      aw_have_q  <= 1'b0;
      w_have_q   <= 1'b0;
      awaddr_q   <= '0;
      wbyte_q    <= 8'h00;
      wstrb0_q   <= 1'b0;
      bresp_q    <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wbyte_q  <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
      case (wr_state_q)
        timer_pkg::WR_COLLECT: begin
          if (wr_do) begin
            wr_state_q <= timer_pkg::WR_RESP;
            aw_have_q  <= 1'b0;
            w_have_q   <= 1'b0;
            bresp_q    <= (wr_dec[8] && (wr_dec[7:0] >= `RUNCTL_IDX) &&
                           (wr_dec[7:0] <= `CLKDIV_IDX)) ?
                          `RESP_OKAY : `RESP_SLVERR;
          end
        end
        timer_pkg::WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_q <= timer_pkg::WR_COLLECT;
          end
        end
        default: wr_state_q <= timer_pkg::WR_COLLECT;
      endcase
    end
  end

  // Readback of control, mode and count bytes
  always_comb begin
    rd_byte = 8'h00;
    case (rd_dec[7:0])
      `RUNCTL_IDX:  rd_byte = {t1_ovf_q, t1_run_q, t0_ovf_q, t0_run_q,
                               x1_req_q, x1_type_q, x0_req_q, x0_type_q};
      `MODESEL_IDX: rd_byte = mode_q;
      `T0LO_IDX:    rd_byte = t0_lo_q;
      `T1LO_IDX:    rd_byte = t1_lo_q;
      `T0HI_IDX:    rd_byte = t0_hi_q;
      `T1HI_IDX:    rd_byte = t1_hi_q;
      `CLKDIV_IDX:  rd_byte = {3'h0, clkdiv_q, 3'h0};
      default:      rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_state_q <= timer_pkg::RD_IDLE;
      rdata_q    <= 32'h0000_0000;
      rresp_q    <= `RESP_OKAY;
    end else begin
      case (rd_state_q)
        timer_pkg::RD_IDLE: begin
          if (s_axi_arvalid) begin
            rd_state_q <= timer_pkg::RD_DATA;
            rdata_q    <= {24'h00_0000, rd_dec[8] ? rd_byte : 8'h00};
            rresp_q    <= (rd_dec[8] && (rd_dec[7:0] >= `RUNCTL_IDX) &&
                           (rd_dec[7:0] <= `CLKDIV_IDX)) ?
                          `RESP_OKAY : `RESP_SLVERR;
          end
        end
        timer_pkg::RD_DATA: begin
          if (s_axi_rready) begin
            rd_state_q <= timer_pkg::RD_IDLE;
          end
        end
        default: rd_state_q <= timer_pkg::RD_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Count enables
  // ****************************************************************
  timer_pkg::mode_t   m0;
  timer_pkg::mode_t   m1;
  timer_pkg::count_t  c0;
  timer_pkg::count_t  c1;
  logic               tick;
  logic               fall_cnt0;
  logic               fall_cnt1;
  logic               fall_x0;
  logic               fall_x1;
  logic               t0_int;
  logic               t1_int;
  logic               t0_en;
  logic               t1_en;
  logic               th0_en;
  logic               wr_ctl;
  logic               t0_ovf_set;
  logic               t1_ovf_set;

  assign m0 = timer_pkg::mode_t'(mode_q[1:0]);
  assign m1 = timer_pkg::mode_t'(mode_q[5:4]);
  assign tick = (div_q == DIV_LAST);
  assign fall_cnt0 = pins_prev_q.count_input_pin_zero &&
                     !pins.count_input_pin_zero;
  assign fall_cnt1 = pins_prev_q.count_input_pin_one &&
                     !pins.count_input_pin_one;
  assign fall_x0 = pins_prev_q.extirq0_pin && !pins.extirq0_pin;
  assign fall_x1 = pins_prev_q.extirq1_pin && !pins.extirq1_pin;
  assign t0_int = clkdiv_q[0] || tick; // RULE19
  assign t1_int = clkdiv_q[1] || tick; // RULE19
  // RULE3 RULE5 RULE11 RULE12 RULE13 RULE14
  assign t0_en = t0_run_q && (!mode_q[`B_GATE0] || pins.extirq0_pin) &&
                 (mode_q[`B_CT0] ? fall_cnt0 : t0_int);
  assign t1_en = t1_run_q && (!mode_q[`B_GATE1] || pins.extirq1_pin) &&
                 (mode_q[`B_CT1] ? fall_cnt1 : t1_int) &&
                 (m1 != timer_pkg::MODE_SPLIT);
  // High half of a split timer 0 runs on timer 1's run bit
  assign th0_en = (m0 == timer_pkg::MODE_SPLIT) && t1_run_q &&
                  t0_int; // RULE16
  assign c0 = step(m0, t0_lo_q, t0_hi_q); // RULE15 RULE21
  assign c1 = step(m1, t1_lo_q, t1_hi_q); // RULE14 RULE21
  assign wr_ctl = wr_en && (wr_dec[7:0] == `RUNCTL_IDX);
  assign t0_ovf_set = t0_en && c0.ovf;
  assign t1_ovf_set = (t1_en && c1.ovf) ||
                      (th0_en && (t0_hi_q == 8'hff)); // RULE16

  always_ff @(posedge clk) begin
    if (reset) begin
      div_q       <= '0;
      pins_prev_q <= '0;
    end else begin
      div_q       <= tick ? '0 : div_q + DIV_W'(1);
      pins_prev_q <= pins;
    end
  end

  // ****************************************************************
  // Control, mode and clock select registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      {t1_run_q, t0_run_q, x1_type_q, x0_type_q} <= 4'h0; // RULE17
      mode_q   <= `RESET_BYTE; // RULE18
      clkdiv_q <= 2'h0;
    end else if (wr_en) begin
      if (wr_dec[7:0] == `RUNCTL_IDX) begin
        t1_run_q  <= wbyte_q[`B_T1RUN];
        t0_run_q  <= wbyte_q[`B_T0RUN];
        x1_type_q <= wbyte_q[`B_X1TYPE]; // RULE10
        x0_type_q <= wbyte_q[`B_X0TYPE]; // RULE10
      end
      if (wr_dec[7:0] == `MODESEL_IDX) begin
        mode_q <= wbyte_q;
      end
      if (wr_dec[7:0] == `CLKDIV_IDX) begin
        clkdiv_q <= {wbyte_q[`B_T1DIV], wbyte_q[`B_T0DIV]};
      end
    end
  end

  // ****************************************************************
  // Overflow and request flags; a hardware set beats any clear
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      t1_ovf_q <= 1'b0;
      t0_ovf_q <= 1'b0;
    end else begin
      if (t1_ovf_set) t1_ovf_q <= 1'b1; // RULE1
      else if (wr_ctl) t1_ovf_q <= wbyte_q[`B_T1OVF]; // RULE1
      else if (isr_ack.t1_ovf) t1_ovf_q <= 1'b0; // RULE2
      if (t0_ovf_set) t0_ovf_q <= 1'b1; // RULE4
      else if (wr_ctl) t0_ovf_q <= wbyte_q[`B_T0OVF]; // RULE4
      else if (isr_ack.t0_ovf) t0_ovf_q <= 1'b0; // RULE4
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      x1_req_q <= 1'b0;
      x0_req_q <= 1'b0;
    end else begin
      if (!x1_type_q) x1_req_q <= !pins.extirq1_pin; // RULE7
      else if (fall_x1) x1_req_q <= 1'b1; // RULE6
      else if (wr_ctl) x1_req_q <= wbyte_q[`B_X1REQ]; // RULE6
      else if (isr_ack.extirq1) x1_req_q <= 1'b0; // RULE6
      if (!x0_type_q) x0_req_q <= !pins.extirq0_pin; // RULE9
      else if (fall_x0) x0_req_q <= 1'b1; // RULE8
      else if (wr_ctl) x0_req_q <= wbyte_q[`B_X0REQ]; // RULE8
      else if (isr_ack.extirq0) x0_req_q <= 1'b0; // RULE8
    end
  end

  assign flags = '{t1_overflow_flag:     t1_ovf_q,
                   t0_overflow_flag:     t0_ovf_q,
                   extirq1_request_flag: x1_req_q,
                   extirq0_request_flag: x0_req_q};

  // ****************************************************************
  // Count bytes; a software write beats counting
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      t0_lo_q <= 8'h00;
      t0_hi_q <= 8'h00;
    end else begin
      if (wr_en && (wr_dec[7:0] == `T0LO_IDX)) t0_lo_q <= wbyte_q; // RULE20
      else if (t0_en) t0_lo_q <= c0.lo; // RULE5 RULE15 RULE21
      if (wr_en && (wr_dec[7:0] == `T0HI_IDX)) t0_hi_q <= wbyte_q; // RULE20
      else if (th0_en) t0_hi_q <= t0_hi_q + 8'h01; // RULE16
      else if (t0_en && (m0 != timer_pkg::MODE_SPLIT)) t0_hi_q <= c0.hi;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      t1_lo_q <= 8'h00;
      t1_hi_q <= 8'h00;
    end else begin
      if (wr_en && (wr_dec[7:0] == `T1LO_IDX)) t1_lo_q <= wbyte_q; // RULE20
      else if (t1_en) t1_lo_q <= c1.lo; // RULE3 RULE14 RULE21
      if (wr_en && (wr_dec[7:0] == `T1HI_IDX)) t1_hi_q <= wbyte_q; // RULE20
      else if (t1_en) t1_hi_q <= c1.hi; // RULE3 RULE14
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic t0_wr;
  logic t1_wr;
  assign t0_wr = wr_en && ((wr_dec[7:0] == `T0LO_IDX) ||
                           (wr_dec[7:0] == `T0HI_IDX));
  assign t1_wr = wr_en && ((wr_dec[7:0] == `T1LO_IDX) ||
                           (wr_dec[7:0] == `T1HI_IDX));

  a_t1_ovf_set: assert property (@(posedge clk) disable iff (reset) // RULE1
    t1_ovf_set |=> t1_ovf_q) else $error("timer 1 overflow flag not set");
  a_t1_isr_clear: assert property (@(posedge clk) disable iff (reset) // RULE2
    isr_ack.t1_ovf && !t1_ovf_set && !wr_ctl |=> !t1_ovf_q)
    else $error("timer 1 flag not cleared on service entry");
  a_t1_run_hold: assert property (@(posedge clk) disable iff (reset) // RULE3
    !t1_run_q && !t1_wr |=> $stable(t1_lo_q) && $stable(t1_hi_q))
    else $error("timer 1 counted while stopped");
  a_t0_ovf_flag: assert property (@(posedge clk) disable iff (reset) // RULE4
    t0_en && c0.ovf && !t0_wr |=> t0_ovf_q && (t0_lo_q == $past(c0.lo)))
    else $error("timer 0 overflow not flagged");
  a_t0_run_hold: assert property (@(posedge clk) disable iff (reset) // RULE5
    !t0_run_q && !t0_wr && (m0 != timer_pkg::MODE_SPLIT)
    |=> $stable(t0_lo_q) && $stable(t0_hi_q))
    else $error("timer 0 counted while stopped");
  a_x1_edge_hold: assert property (@(posedge clk) disable iff (reset) // RULE6
    x1_type_q && fall_x1 |=> x1_req_q [*2] or (x1_req_q ##1 !x1_type_q)
    or (x1_req_q ##1 (wr_ctl || isr_ack.extirq1)))
    else $error("edge request 1 lost");
  a_x1_level: assert property (@(posedge clk) disable iff (reset) // RULE7
    !x1_type_q |=> x1_req_q == !$past(pins.extirq1_pin))
    else $error("level request 1 does not follow pin");
  a_x0_edge_set: assert property (@(posedge clk) disable iff (reset) // RULE8
    x0_type_q && fall_x0 |=> x0_req_q)
    else $error("edge request 0 not set");
  a_x0_level: assert property (@(posedge clk) disable iff (reset) // RULE9
    !x0_type_q && wr_ctl |=> x0_req_q == !$past(pins.extirq0_pin))
    else $error("level request 0 changed by software");
  a_gate_block: assert property (@(posedge clk) disable iff (reset) // RULE11
    mode_q[`B_GATE1] && !pins.extirq1_pin && !t1_wr |=> $stable(t1_lo_q))
    else $error("gated timer 1 counted with gate low");
  a_reload_copy: assert property (@(posedge clk) disable iff (reset) // RULE21
    t0_en && (m0 == timer_pkg::MODE_RELOAD) && (t0_lo_q == 8'hff) && !t0_wr
    |=> t0_lo_q == $past(t0_hi_q))
    else $error("auto-reload did not copy high byte");
  a_t1_mode_halt: assert property (@(posedge clk) disable iff (reset) // RULE14
    (m1 == timer_pkg::MODE_SPLIT) && !t1_wr
    |=> $stable(t1_lo_q) && $stable(t1_hi_q))
    else $error("timer 1 counted in halt mode");
  a_split_high: assert property (@(posedge clk) disable iff (reset) // RULE16
    th0_en && (t0_hi_q == 8'hff) && !t0_wr |=> t1_ovf_q && (t0_hi_q == 8'h00))
    else $error("split high byte overflow wrong");

  c_t0_13bit_ovf: cover property (@(posedge clk) disable iff (reset)
    t0_en && (m0 == timer_pkg::MODE_13BIT) && c0.ovf);
  c_t1_reload: cover property (@(posedge clk) disable iff (reset)
    t1_en && (m1 == timer_pkg::MODE_RELOAD) && c1.ovf);
  c_split_ovf: cover property (@(posedge clk) disable iff (reset)
    th0_en && (t0_hi_q == 8'hff));
  c_edge_req: cover property (@(posedge clk) disable iff (reset)
    x0_type_q && fall_x0 ##1 isr_ack.extirq0);
endmodule

// ===== test/pin_model.sv
// Far-side model of the count and interrupt input pins
`timescale 1ns/1ps
module pin_model (
  input  wire logic        clk,
  input  wire logic [3:0]  level,
  output timer_pkg::pins_t pins
);
  // Pins follow the commanded levels one cycle later
  always_ff @(posedge clk) begin
    pins <= timer_pkg::pins_t'(level);
  end
endmodule

// ===== test/tb_dual_timer_extint_control.sv
// Self-checking bench for the timer and external interrupt block
`timescale 1ns/1ps
`include "timer_defines.svh"
module tb_dual_timer_extint_control;
  logic              clk, reset, s_axi_awvalid, s_axi_awready;
  logic              s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic              s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready;
  logic [11:0]       s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb, level;
  logic [1:0]        s_axi_bresp, s_axi_rresp, wr_resp;
  timer_pkg::pins_t  pins;
  timer_pkg::ack_t   isr_ack;
  timer_pkg::flags_t flags;
  int                fail_count, checks;

  dual_timer_extint_control #(.ADDR_W(12), .PRESCALE(12))
    dual_timer_extint_control_inst (
    .clk(clk), .reset(reset), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pins(pins), .isr_ack(isr_ack), .flags(flags));
  pin_model pin_model_inst (.clk(clk), .level(level), .pins(pins));

  always #10 clk = ~clk;

  // ********
  // Bus and compare tasks
  // ********
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic fc(input string n, input logic g, input logic e);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    bit a, w;
    a = 0;
    w = 0;
    s_axi_awaddr <= {2'b00, i, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(a && w)) begin
      @(posedge clk);
      if (!a) a = s_axi_awready;
      if (!w) w = s_axi_wready;
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    do @(posedge clk); while (!s_axi_bvalid);
    wr_resp = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] i, output logic [31:0] d,
                    output logic [1:0] r);
    s_axi_araddr <= {2'b00, i, 2'b00};
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic rc(input string n, input logic [7:0] i,
                    input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(i, d, r);
    chk(n, e, d);
  endtask
  task automatic ack(input timer_pkg::ack_t a);
    isr_ack <= a;
    @(posedge clk);
    isr_ack <= '0;
    @(posedge clk);
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      level[1] <= 1'b0;
      repeat (2) @(posedge clk);
      level[1] <= 1'b1;
      @(posedge clk);
    end
  endtask

  // ********
  // Scenarios
  // ********
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    rc("ctl reset", `RUNCTL_IDX, 32'h0);
    rc("mode reset", `MODESEL_IDX, 32'h0);
    rd(8'h8f, d, r);
    chk("unmapped resp", 32'h2, {30'h0, r});
    wr(8'h8f, 8'h00);
    chk("unmapped wr resp", 32'h2, {30'h0, wr_resp});
    wr(`MODESEL_IDX, 8'h00);
    chk("mapped wr resp", 32'h0, {30'h0, wr_resp});
  endtask
  task automatic t_timer0;
    int k;
    logic [31:0] d;
    logic [1:0]  r;
    wr(`CLKDIV_IDX, 8'h08);
    wr(`MODESEL_IDX, 8'h01);
    wr(`T0LO_IDX, 8'hf0);
    wr(`T0HI_IDX, 8'hff);
    wr(`RUNCTL_IDX, 8'h10);
    for (k = 0; k < 64 && flags.t0_overflow_flag !== 1'b1; k++)
      @(posedge clk);
    fc("t0 ovf", flags.t0_overflow_flag, 1'b1);
    rc("t0 high wrap", `T0HI_IDX, 32'h0);
    ack(4'b0100);
    fc("t0 ovf ack", flags.t0_overflow_flag, 1'b0);
    wr(`RUNCTL_IDX, 8'h80);
    rc("t1 ovf sw", `RUNCTL_IDX, 32'h80);
    rd(`T0LO_IDX, d, r);
    rc("t0 low held", `T0LO_IDX, d);
    ack(4'b1000);
    rc("t1 ovf ack", `RUNCTL_IDX, 32'h0);
    wr(`CLKDIV_IDX, 8'h00);
    wr(`MODESEL_IDX, 8'h02);
    wr(`T0HI_IDX, 8'hf8);
    wr(`T0LO_IDX, 8'hfe);
    wr(`RUNCTL_IDX, 8'h10);
    for (k = 0; k < 64 && flags.t0_overflow_flag !== 1'b1; k++)
      @(posedge clk);
    fc("t0 reload ovf", flags.t0_overflow_flag, 1'b1);
    rc("t0 reload", `T0LO_IDX, 32'hf8);
  endtask
  task automatic t_extint;
    wr(`RUNCTL_IDX, 8'h00);
    level <= 4'b0011;
    repeat (3) @(posedge clk);
    fc("ext1 level", flags.extirq1_request_flag, 1'b1);
    fc("ext0 level", flags.extirq0_request_flag, 1'b1);
    wr(`RUNCTL_IDX, 8'h00);
    fc("ext0 sw", flags.extirq0_request_flag, 1'b1);
    level <= 4'b1111;
    repeat (3) @(posedge clk);
    fc("ext1 release", flags.extirq1_request_flag, 1'b0);
    wr(`RUNCTL_IDX, 8'h05);
    level <= 4'b1011;
    repeat (3) @(posedge clk);
    fc("ext0 edge", flags.extirq0_request_flag, 1'b1);
    fc("ext1 idle", flags.extirq1_request_flag, 1'b0);
    level <= 4'b0111;
    ack(4'b0001);
    @(posedge clk);
    fc("ext0 ack", flags.extirq0_request_flag, 1'b0);
    fc("ext1 edge", flags.extirq1_request_flag, 1'b1);
    wr(`RUNCTL_IDX, 8'h05);
    fc("ext1 sw clr", flags.extirq1_request_flag, 1'b0);
    level <= 4'b1111;
  endtask
  task automatic t_counter;
    wr(`MODESEL_IDX, 8'h50);
    wr(`T1LO_IDX, 8'h00);
    wr(`RUNCTL_IDX, 8'h40);
    pulses(3);
    rc("t1 pin count", `T1LO_IDX, 32'h3);
    wr(`MODESEL_IDX, 8'hd0);
    level <= 4'b0111;
    pulses(2);
    rc("t1 gate low", `T1LO_IDX, 32'h3);
    level[3] <= 1'b1;
    pulses(2);
    rc("t1 gate high", `T1LO_IDX, 32'h5);
    wr(`MODESEL_IDX, 8'h70);
    pulses(2);
    rc("t1 mode3", `T1LO_IDX, 32'h5);
  endtask

  task automatic test_done;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    clk = 0;
    reset = 1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_bready, s_axi_rready} = 2'b11;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    level = 4'hf;
    isr_ack = '0;
    fail_count = 0;
    checks = 0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset();
    t_timer0();
    t_extint();
    t_counter();
    test_done();
  end
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    test_done();
  end
endmodule
